// ### core/bcr_device.sv
/*
  Device end: divides the system clock into the expansion clock, turns
  error pulses into an NMI, drives the expansion reset and CPU controls,
  and owns one side of a sustained tri-state line.
  Assumes rst_b may move at any time relative to clk_sys and is clean.
*/
`timescale 1ns/1ps
// Functional notes
// - Expansion clock is system clock over 3/4
// - Shared line ownership timed on returned clock edges
// - Parity error input raises NMI
// - System error input raises NMI
// - Error pulses accepted from any agent
// - Reset returns all state to defaults
// - Reset may change at any time
// - Expansion reset derived from system reset
// - CPU control outputs held low in reset
// - Drive high one clock before floating
// - Wait one clock before taking ownership
// - Hash-suffixed (_n) signals are active low
module bcr_device #(
  parameter int SYNC_DEPTH = bcr_pkg::SYNC_STAGES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Configuration
  input wire logic div_by_four,
  // User requests
  input wire logic want_line,
  input wire logic drive_low,
  input wire logic cpu_interrupt_req_in,
  input wire logic ignore_numeric_error_req,
  input wire logic mgmt_interrupt_req,
  input wire logic alt_cpu_reset_req,
  input wire logic cpu_clock_stop_req,
  input wire logic alt_addr20_req,
  input wire logic nmi_clear,
  // CPU side
  output logic cpu_interrupt_request,
  output logic nmi,
  output logic ignore_numeric_error_n,
  output logic mgmt_interrupt_n,
  output logic alt_cpu_reset_n,
  output logic cpu_clock_stop_n,
  output logic alt_addr20_gate,
  output logic line_owned,
  // Link
  bcr_link_if.dev link
);
  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (SYNC_DEPTH < 2) begin : g_bad_depth
    $error("SYNC_DEPTH must be at least 2");
  end

  // ---------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------
  // Reset is sampled into a chain; assertion clears the whole chain in one clock,
  // while release reaches the chain end after the depth, so nothing reacts to a bare metastable edge.
  logic [SYNC_DEPTH-1:0] rst_sync_reg;
  logic [SYNC_DEPTH-1:0] rst_sync_next;
  logic run;
  always_comb begin
    rst_sync_next = {rst_sync_reg[SYNC_DEPTH-2:0], 1'b1};
    if (!rst_b) begin
      rst_sync_next = '0;
    end
  end
  always_ff @(posedge clk_sys) begin
    rst_sync_reg <= rst_sync_next;
  end
  assign run = rst_sync_reg[SYNC_DEPTH-1];

  // ---------------------------------------------------------------
  // Clock divider
  // ---------------------------------------------------------------
  logic [1:0] div_cnt_reg;
  logic [1:0] div_cnt_next;
  logic ratio_four_reg;
  logic ratio_four_next;
  logic clk_out_reg;
  logic clk_out_next;
  logic [2:0] div_ratio;
  always_comb begin
    ratio_four_next = ratio_four_reg;
    if (!run) begin
      ratio_four_next = div_by_four;
    end
    div_ratio = ratio_four_reg ? bcr_pkg::DIV_FOUR : bcr_pkg::DIV_THREE;
    if (!run || ({1'b0, div_cnt_reg} == div_ratio - 3'h1)) begin
      div_cnt_next = bcr_pkg::DIV_CNT_RST;
    end else begin
      div_cnt_next = div_cnt_reg + 2'h1;
    end
    // High for the first half, rounded down, so /3 gives one high, two low.
    clk_out_next = run && ({1'b0, div_cnt_next} < (div_ratio >> 1));
  end
  always_ff @(posedge clk_sys) begin
    div_cnt_reg <= div_cnt_next;
    ratio_four_reg <= ratio_four_next;
    clk_out_reg <= clk_out_next;
  end
  assign link.expansion_clock_out = clk_out_reg;

  // ---------------------------------------------------------------
  // Returned clock edge detection
  // ---------------------------------------------------------------
  // The returned clock is taken as synchronous; edges become strobes that
  // time the tri-state ownership steps; error inputs and expansion reset run on every clock.
  logic back_reg;
  logic rise_reg;
  logic fall_reg;
  logic rise_next;
  logic fall_next;
  always_comb begin
    rise_next = run && link.expansion_clock_back && !back_reg;
    fall_next = run && !link.expansion_clock_back && back_reg;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      back_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      back_reg <= link.expansion_clock_back;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end
  assign link.exp_sample_rise = rise_reg;
  assign link.exp_sample_fall = fall_reg;

  // ---------------------------------------------------------------
  // Error to NMI and CPU controls
  // ---------------------------------------------------------------
  // NMI is sticky; a new error in the clear cycle keeps it set.
  logic nmi_reg;
  logic nmi_next;
  logic [5:0] ctl_reg;
  logic [5:0] ctl_next;
  logic xrst_reg;
  always_comb begin
    nmi_next = nmi_reg && !nmi_clear;
    if (!link.parity_error_n) begin
      nmi_next = 1'b1;
    end
    if (!link.system_error_n) begin
      nmi_next = 1'b1;
    end
    ctl_next = {cpu_interrupt_req_in, !ignore_numeric_error_req, !mgmt_interrupt_req,
                !alt_cpu_reset_req, !cpu_clock_stop_req, alt_addr20_req};
    if (!run) begin
      nmi_next = 1'b0;
      ctl_next = '0;
    end
  end
  always_ff @(posedge clk_sys) begin
    nmi_reg <= nmi_next;
    ctl_reg <= ctl_next;
    xrst_reg <= !run;
  end
  assign link.expansion_reset = xrst_reg;
  assign cpu_interrupt_request = ctl_reg[5];
  assign ignore_numeric_error_n = ctl_reg[4];
  assign mgmt_interrupt_n = ctl_reg[3];
  assign alt_cpu_reset_n = ctl_reg[2];
  assign cpu_clock_stop_n = ctl_reg[1];
  assign alt_addr20_gate = ctl_reg[0];
  assign nmi = nmi_reg;

  // ---------------------------------------------------------------
  // Sustained tri-state ownership
  // ---------------------------------------------------------------
  bcr_pkg::bcr_own_e own_reg;
  bcr_pkg::bcr_own_e own_next;
  logic [1:0] wait_reg;
  logic [1:0] wait_next;
  logic far_seen_reg;
  logic oe_reg;
  logic out_reg;
  always_comb begin
    own_next = own_reg;
    wait_next = wait_reg;
    case (own_reg)
      bcr_pkg::BCR_IDLE: begin
        // Taking the line needs one clock of float after the last owner.
        if (rise_reg && want_line && !link.sts_far_oe && !far_seen_reg) begin
          own_next = bcr_pkg::BCR_DRIVE;
        end
      end
      bcr_pkg::BCR_DRIVE: begin
        if (rise_reg && !want_line) begin
          own_next = bcr_pkg::BCR_PARK;
          wait_next = bcr_pkg::PARK_CLOCKS;
        end
      end
      bcr_pkg::BCR_PARK: begin
        if (rise_reg) begin
          wait_next = wait_reg - 2'h1;
          if (wait_reg == 2'h1) begin
            own_next = bcr_pkg::BCR_TURN;
            wait_next = bcr_pkg::TURN_CLOCKS;
          end
        end
      end
      bcr_pkg::BCR_TURN: begin
        if (rise_reg) begin
          own_next = bcr_pkg::BCR_IDLE;
        end
      end
      default: own_next = bcr_pkg::BCR_IDLE;
    endcase
    if (!run) begin
      own_next = bcr_pkg::BCR_IDLE;
      wait_next = 2'h0;
    end
  end
  always_ff @(posedge clk_sys) begin
    own_reg <= own_next;
    wait_reg <= wait_next;
    if (!run) begin
      far_seen_reg <= 1'b0;
    end else if (rise_reg) begin
      far_seen_reg <= link.sts_far_oe;
    end
    line_owned <= (own_next == bcr_pkg::BCR_DRIVE);
    oe_reg <= (own_next == bcr_pkg::BCR_DRIVE) || (own_next == bcr_pkg::BCR_PARK);
    out_reg <= (own_next == bcr_pkg::BCR_DRIVE) ? !drive_low : 1'b1;
  end
  assign link.sts_dev_oe = oe_reg;
  assign link.sts_dev_out = out_reg;
endmodule : bcr_device

// ### core/bcr_partner.sv
/*
  Partner end: buffers the expansion clock back, pulses error lines on
  request and shares the sustained tri-state line under the same handover.
  Assumes the same clk_sys as the device end.
*/
`timescale 1ns/1ps
module bcr_partner (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // User requests
  input wire logic parity_error_req,
  input wire logic system_error_req,
  input wire logic want_line,
  input wire logic drive_low,
  // User status
  output logic line_owned,
  output logic in_expansion_reset,
  // Link
  bcr_link_if.far link
);
  // ---------------------------------------------------------------
  // Clock return, error pulses
  // ---------------------------------------------------------------
  logic back_reg;
  logic perr_n_reg;
  logic serr_n_reg;
  logic rise_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      back_reg <= 1'b0;
      perr_n_reg <= 1'b1;
      serr_n_reg <= 1'b1;
      rise_reg <= 1'b0;
      in_expansion_reset <= 1'b1;
    end else begin
      back_reg <= link.expansion_clock_out;
      perr_n_reg <= !parity_error_req;
      serr_n_reg <= !system_error_req;
      rise_reg <= link.expansion_clock_out && !back_reg;
      in_expansion_reset <= link.expansion_reset;
    end
  end
  assign link.expansion_clock_back = back_reg;
  assign link.parity_error_n = perr_n_reg;
  assign link.system_error_n = serr_n_reg;

  // ---------------------------------------------------------------
  // Sustained tri-state ownership
  // ---------------------------------------------------------------
  bcr_pkg::bcr_own_e own_reg;
  bcr_pkg::bcr_own_e own_next;
  logic dev_seen_reg;
  always_comb begin
    own_next = own_reg;
    case (own_reg)
      bcr_pkg::BCR_IDLE: begin
        if (rise_reg && want_line && !link.sts_dev_oe && !dev_seen_reg) begin
          own_next = bcr_pkg::BCR_DRIVE;
        end
      end
      bcr_pkg::BCR_DRIVE: begin
        if (rise_reg && !want_line) begin
          own_next = bcr_pkg::BCR_PARK;
        end
      end
      bcr_pkg::BCR_PARK: begin
        if (rise_reg) begin
          own_next = bcr_pkg::BCR_TURN;
        end
      end
      bcr_pkg::BCR_TURN: begin
        if (rise_reg) begin
          own_next = bcr_pkg::BCR_IDLE;
        end
      end
      default: own_next = bcr_pkg::BCR_IDLE;
    endcase
    if (link.expansion_reset) begin
      own_next = bcr_pkg::BCR_IDLE;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      own_reg <= bcr_pkg::BCR_IDLE;
      dev_seen_reg <= 1'b0;
      line_owned <= 1'b0;
    end else begin
      own_reg <= own_next;
      if (rise_reg) begin
        dev_seen_reg <= link.sts_dev_oe;
      end
      line_owned <= (own_next == bcr_pkg::BCR_DRIVE);
    end
  end
  assign link.sts_far_oe = (own_reg == bcr_pkg::BCR_DRIVE) || (own_reg == bcr_pkg::BCR_PARK);
  assign link.sts_far_out = (own_reg == bcr_pkg::BCR_DRIVE) ? !drive_low : 1'b1;
endmodule : bcr_partner

// ### dv/bcr_link_asserts.sv
/*
  Checker on the link between the device end and the partner end.
  Assumes one clk_sys and the synchronous active-low rst_b of both ends.
*/
`timescale 1ns/1ps
module bcr_link_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Link
  input wire logic expansion_clock_out,
  input wire logic expansion_clock_back,
  input wire logic expansion_reset,
  input wire logic exp_sample_rise,
  input wire logic exp_sample_fall,
  input wire logic sts_dev_out,
  input wire logic sts_dev_oe,
  input wire logic sts_far_out,
  input wire logic sts_far_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  // ----------------------------------------
  // Reset
  // ----------------------------------------
  a_exprst_in_reset: assert property (!rst_b [*4] |-> expansion_reset)
    else $error("expansion reset low during reset");
  a_exprst_release: assert property (rst_b [*6] |-> !expansion_reset)
    else $error("expansion reset still high after release");
  // ----------------------------------------
  // Expansion clock
  // ----------------------------------------
  a_clk_low_two: assert property (disable iff (!rst_b) $fell(expansion_clock_out) |-> ##1 !expansion_clock_out ##1 expansion_clock_out)
    else $error("expansion clock low phase not two cycles");
  a_clk_high_len: assert property (disable iff (!rst_b) $rose(expansion_clock_out) |-> ##[1:2] !expansion_clock_out)
    else $error("expansion clock high phase too long");
  a_back_copy: assert property (disable iff (!rst_b) $past(rst_b) |-> expansion_clock_back == $past(expansion_clock_out))
    else $error("returned clock is not a one cycle copy");
  a_sample_on_back: assert property (disable iff (!rst_b) $rose(expansion_clock_back) |-> ##[0:3] exp_sample_rise)
    else $error("no sample strobe after returned clock rise");
  a_fall_strobe: assert property (disable iff (!rst_b)
    $fell(expansion_clock_back) |-> ##[0:3] exp_sample_fall)
    else $error("no sample strobe after returned clock fall");
  // ----------------------------------------
  // Shared line handover
  // ----------------------------------------
  a_dev_park: assert property (disable iff (!rst_b) $fell(sts_dev_oe) |-> $past(sts_dev_out) && $past(sts_dev_out, 3))
    else $error("device floated the line without parking high");
  a_far_park: assert property (disable iff (!rst_b) $fell(sts_far_oe) |-> $past(sts_far_out) && $past(sts_far_out, 3))
    else $error("partner floated the line without parking high");
  a_dev_wait: assert property (disable iff (!rst_b) $rose(sts_dev_oe) |-> !$past(sts_far_oe) && !$past(sts_far_oe, 3))
    else $error("device drove the line too soon");
  a_far_wait: assert property (disable iff (!rst_b) $rose(sts_far_oe) |-> !$past(sts_dev_oe) && !$past(sts_dev_oe, 3))
    else $error("partner drove the line too soon");
  c_dev_release: cover property ($fell(sts_dev_oe));
  c_far_release: cover property ($fell(sts_far_oe));
  c_reset_end: cover property ($fell(expansion_reset));
endmodule : bcr_link_asserts

// ### dv/tb_bus_clock_reset_error_front.sv
/*
  Bench joining both ends over the link and driving both user sides.
  Assumes the package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
module tb_bus_clock_reset_error_front;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic div_by_four = 1'b0;
  logic d_want = 1'b0;
  logic d_low = 1'b0;
  logic [5:0] req = 6'h00;
  logic nmi_clear = 1'b0;
  logic p_perr = 1'b0;
  logic p_serr = 1'b0;
  logic p_want = 1'b0;
  logic p_low = 1'b0;
  logic irq, nmi, ine_n, mgmt_n, art_n, stop_n, a20, d_owned, p_owned, p_inrst;
  int fails = 0;
  int n_tests = 0;
  // Request bits beside the CPU outputs they give; the _n outputs invert.
  logic [11:0] rows [6] = '{12'h01E, 12'hFE1, 12'h54B, 12'hAB4, 12'h05F, 12'h83E};
  always #50 clk_sys = ~clk_sys;
  bcr_link_if link ();
  bcr_device i_bcr_device (.clk_sys(clk_sys), .rst_b(rst_b), .div_by_four(div_by_four), .want_line(d_want),
    .drive_low(d_low), .cpu_interrupt_req_in(req[5]), .ignore_numeric_error_req(req[4]),
    .mgmt_interrupt_req(req[3]), .alt_cpu_reset_req(req[2]), .cpu_clock_stop_req(req[1]),
    .alt_addr20_req(req[0]), .nmi_clear(nmi_clear), .cpu_interrupt_request(irq), .nmi(nmi),
    .ignore_numeric_error_n(ine_n), .mgmt_interrupt_n(mgmt_n), .alt_cpu_reset_n(art_n),
    .cpu_clock_stop_n(stop_n), .alt_addr20_gate(a20), .line_owned(d_owned), .link(link));
  bcr_partner i_bcr_partner (.clk_sys(clk_sys), .rst_b(rst_b), .parity_error_req(p_perr),
    .system_error_req(p_serr), .want_line(p_want), .drive_low(p_low), .line_owned(p_owned),
    .in_expansion_reset(p_inrst), .link(link));
  bcr_link_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .expansion_clock_out(link.expansion_clock_out),
    .expansion_clock_back(link.expansion_clock_back), .expansion_reset(link.expansion_reset),
    .exp_sample_rise(link.exp_sample_rise), .sts_dev_out(link.sts_dev_out), .sts_dev_oe(link.sts_dev_oe),
    .sts_far_out(link.sts_far_out), .sts_far_oe(link.sts_far_oe), .exp_sample_fall(link.exp_sample_fall));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task check(string name, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  function logic cur(int sel);
    case (sel)
      0: return nmi;
      1: return p_owned;
      2: return d_owned;
      3: return !link.expansion_clock_out;
      default: return link.expansion_clock_out;
    endcase
  endfunction : cur
  // A wait that runs out counts as a mismatch and ends the run.
  task wait_hi(int sel, output int n);
    n = 0;
    while (cur(sel) !== 1'b1) begin
      tick();
      n++;
      if (n > 300) begin
        fails++;
        $display("CHECK FAILED wait %0d expected 1 seen timeout", sel);
        tally_and_finish();
      end
    end
  endtask : wait_hi
  task period(output int n);
    int c, h, l;
    wait_hi(3, c);
    wait_hi(4, c);
    wait_hi(3, h);
    wait_hi(4, l);
    n = h + l;
  endtask : period
  task do_reset(logic four);
    rst_b = 1'b0;
    div_by_four = four;
    repeat (12) tick();
    check("cpu_outs_rst", 8'({irq, nmi, ine_n, mgmt_n, art_n, stop_n, a20}), 8'h00);
    check("exp_reset", 8'({link.expansion_reset, p_inrst}), 8'h03);
    rst_b = 1'b1;
    tick();
    check("exp_reset_sync", 8'(link.expansion_reset), 8'h01);
    repeat (4) tick();
    check("post_reset", 8'({link.expansion_reset, nmi, d_owned, p_owned}), 8'h00);
    $display("test reset done");
  endtask : do_reset
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n, c;
    do_reset(1'b0);
    foreach (rows[i]) begin
      req = rows[i][11:6];
      tick();
      check("cpu_outs", 8'({irq, ine_n, mgmt_n, art_n, stop_n, a20}), 8'(rows[i][5:0]));
    end
    req = 6'h00;
    $display("test cpu controls done");
    period(n);
    check("div3", 8'(n), 8'(bcr_pkg::DIV_THREE));
    div_by_four = 1'b1;
    repeat (8) tick();
    period(n);
    check("div_hold", 8'(n), 8'(bcr_pkg::DIV_THREE));
    $display("test ratio done");
    for (int k = 0; k < 2; k++) begin
      {p_serr, p_perr} = 2'(k + 1);
      tick();
      {p_serr, p_perr} = 2'b00;
      wait_hi(0, c);
      check("nmi_lat", 8'(c < 4), 8'h01);
      repeat (5) tick();
      check("nmi_sticky", 8'(nmi), 8'h01);
      nmi_clear = 1'b1;
      tick();
      nmi_clear = 1'b0;
      tick();
      check("nmi_clr", 8'(nmi), 8'h00);
    end
    // An error in the same cycle as the clear must still set the interrupt.
    p_perr = 1'b1;
    tick();
    p_perr = 1'b0;
    nmi_clear = 1'b1;
    tick();
    nmi_clear = 1'b0;
    tick();
    check("nmi_err_wins", 8'(nmi), 8'h01);
    $display("test nmi done");
    d_want = 1'b1;
    d_low = 1'b1;
    wait_hi(2, c);
    tick();
    check("dev_low", 8'(link.sts_line), 8'h00);
    p_want = 1'b1;
    repeat (10) tick();
    check("far_waits", 8'(p_owned), 8'h00);
    d_want = 1'b0;
    wait_hi(1, c);
    check("dev_gone", 8'({d_owned, link.sts_dev_oe}), 8'h00);
    check("handover_gap", 8'(c >= 6), 8'h01);
    p_low = 1'b1;
    tick();
    tick();
    check("far_low", 8'(link.sts_line), 8'h00);
    $display("test handover done");
    p_want = 1'b0;
    do_reset(1'b1);
    period(n);
    check("div4", 8'(n), 8'(bcr_pkg::DIV_FOUR));
    $display("test ratio four done");
    tally_and_finish();
  end
endmodule : tb_bus_clock_reset_error_front

// ### include/bcr_link_if.sv
/*
  Link between the device end and the partner end: expansion clock,
  expansion reset, error pulses and one shared sustained tri-state line.
  Resolves the shared line here, pulled up when neither end enables a driver.
*/
`timescale 1ns/1ps
interface bcr_link_if;
  logic expansion_clock_out;
  logic expansion_clock_back;
  logic expansion_reset;
  logic parity_error_n;
  logic system_error_n;
  logic sts_dev_out;
  logic sts_dev_oe;
  logic sts_far_out;
  logic sts_far_oe;
  logic sts_line;
  logic exp_sample_rise;
  logic exp_sample_fall;
  // Pulled high when nobody drives; low wins only from an enabled driver.
  assign sts_line = (sts_dev_oe ? sts_dev_out : 1'b1) & (sts_far_oe ? sts_far_out : 1'b1);
  modport dev (
    output expansion_clock_out,
    input expansion_clock_back,
    output expansion_reset,
    input parity_error_n,
    input system_error_n,
    output sts_dev_out,
    output sts_dev_oe,
    input sts_far_oe,
    input sts_line,
    output exp_sample_rise,
    output exp_sample_fall
  );
  modport far (
    input expansion_clock_out,
    output expansion_clock_back,
    input expansion_reset,
    output parity_error_n,
    output system_error_n,
    output sts_far_out,
    output sts_far_oe,
    input sts_dev_oe,
    input sts_line
  );
endinterface : bcr_link_if

// ### include/bcr_pkg.sv
/*
  Shared constants for the bus clock, reset and error front end and its
  partner end. Assumes a single system clock of 10 MHz driving both ends.
*/
package bcr_pkg;
  // ---------------------------------------------------------------
  // Clock division
  // ---------------------------------------------------------------
  localparam logic [2:0] DIV_THREE = 3'h3;
  localparam logic [2:0] DIV_FOUR = 3'h4;
  localparam logic [1:0] DIV_CNT_RST = 2'h0;
  // ---------------------------------------------------------------
  // Sustained tri-state handover, in clocks
  // ---------------------------------------------------------------
  localparam logic [1:0] PARK_CLOCKS = 2'h1;
  localparam logic [1:0] TURN_CLOCKS = 2'h1;
  // ---------------------------------------------------------------
  // Reset synchroniser depth
  // ---------------------------------------------------------------
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    BCR_IDLE = 2'h0,
    BCR_DRIVE = 2'h1,
    BCR_PARK = 2'h3,
    BCR_TURN = 2'h2
  } bcr_own_e;
endpackage : bcr_pkg
